// >>> design/mode_ctrl_pkg.sv
// shared constants for the operating mode and system control block
package mode_ctrl_pkg;
	// ==========================================
	// register map
	localparam logic [15:0] ADDR_MODE_READBACK = 16'hfff1;
	localparam logic [15:0] ADDR_SYSTEM_CONTROL = 16'hfff2;
	localparam logic [7:0] SYSCTL_RESET = 8'h0b;
	localparam logic [7:0] READBACK_FIXED = 8'hc0;
	localparam logic [7:0] SYSCTL_WRITABLE = 8'hfd;
	localparam logic [7:0] SYSCTL_FIXED_ONE = 8'h02;
	// ==========================================
	// field positions
	localparam int BIT_STANDBY = 7;
	localparam int BIT_SETTLE_HI = 6;
	localparam int BIT_SETTLE_LO = 4;
	localparam int BIT_USER_EN = 3;
	localparam int BIT_EDGE = 2;
	localparam int BIT_RAM_EN = 0;
	// ==========================================
	// mode numbers
	localparam logic [2:0] MODE_NONE = 3'h0;
	localparam logic [2:0] MODE_1 = 3'h1;
	localparam logic [2:0] MODE_2 = 3'h2;
	localparam logic [2:0] MODE_3 = 3'h3;
	localparam logic [2:0] MODE_4 = 3'h4;
	localparam logic [2:0] MODE_5 = 3'h5;
	localparam logic [2:0] MODE_6 = 3'h6;
	localparam logic [2:0] MODE_7 = 3'h7;
	// address space size codes
	localparam logic [1:0] SPACE_NONE = 2'h0;
	localparam logic [1:0] SPACE_64K = 2'h1;
	localparam logic [1:0] SPACE_1M = 2'h2;
	localparam logic [1:0] SPACE_16M = 2'h3;
	// settle wait in states
	localparam logic [17:0] WAIT_8K = 18'h02000;
	localparam logic [17:0] WAIT_16K = 18'h04000;
	localparam logic [17:0] WAIT_32K = 18'h08000;
	localparam logic [17:0] WAIT_64K = 18'h10000;
	localparam logic [17:0] WAIT_128K = 18'h20000;
	localparam logic [17:0] WAIT_ILLEGAL = 18'h00000;
	localparam logic [19:0] ADDR_1M_MASK = 20'hfffff;
endpackage

// >>> design/mode_ctrl.sv
// operating mode decode and system control register bank
//
// Implementation choice: the plain strobed port.
`timescale 1ns/100ps
module mode_ctrl (
	input wire logic clock_i,
	input wire logic rst_i,
	input wire logic [2:0] mode_pins_i,
	input wire logic [15:0] addr_i,
	input wire logic [7:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	input wire logic [7:0] area_width_control_i,
	input wire logic sleep_i,
	input wire logic [19:0] cpu_addr_i,
	output logic [7:0] rdata_o,
	output logic [2:0] mode_o,
	output logic mode_valid_o,
	output logic bus_16bit_o,
	output logic rom_enable_o,
	output logic [1:0] addr_space_o,
	output logic single_chip_o,
	output logic advanced_o,
	output logic ports_address_o,
	output logic [19:0] ext_addr_o,
	output logic ram_select_o,
	output logic enter_sleep_o,
	output logic enter_standby_o,
	output logic [17:0] settle_wait_o,
	output logic settle_illegal_o,
	output logic user_flag_enable_bit_o,
	output logic nmi_rising_o
);
	// ==========================================
	// pin synchroniser; first stage feeds only the second
	logic [2:0] pin_meta_r;
	logic [2:0] pin_sync_r;
	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			pin_meta_r <= 3'h0;
			pin_sync_r <= 3'h0;
		end else begin
			pin_meta_r <= mode_pins_i;
			pin_sync_r <= pin_meta_r;
		end
	end

	// ==========================================
	// system control register
	logic [7:0] sysctl_r;
	logic [7:0] sysctl_nxt;
	// reserved bit forced on write so it always reads as one
	always_comb begin
		sysctl_nxt = sysctl_r;
		if (wr_i && addr_i == mode_ctrl_pkg::ADDR_SYSTEM_CONTROL) begin
			sysctl_nxt = (wdata_i & mode_ctrl_pkg::SYSCTL_WRITABLE)
				| mode_ctrl_pkg::SYSCTL_FIXED_ONE;
		end
	end
	// standby exit never touches it, so standby and ram bits hold
	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			sysctl_r <= mode_ctrl_pkg::SYSCTL_RESET;
		end else begin
			sysctl_r <= sysctl_nxt;
		end
	end

	// ==========================================
	// register read; synchronised pins, two cycles behind mode_pins_i, sampled in the read cycle
	logic [7:0] rdata_nxt;
	always_comb begin
		rdata_nxt = 8'h00;
		if (rd_i) begin
			case (addr_i)
				mode_ctrl_pkg::ADDR_MODE_READBACK: begin
					rdata_nxt = mode_ctrl_pkg::READBACK_FIXED
						| {5'h00, pin_sync_r};
				end
				mode_ctrl_pkg::ADDR_SYSTEM_CONTROL: begin
					rdata_nxt = sysctl_r;
				end
				default: begin
					rdata_nxt = 8'h00;
				end
			endcase
		end
	end

	// ==========================================
	// mode decode
	logic [2:0] mode_nxt;
	logic valid_nxt;
	logic bus16_nxt;
	logic rom_nxt;
	logic [1:0] space_nxt;
	logic single_nxt;
	logic adv_nxt;
	logic ports_nxt;
	logic expanded;
	logic init16;
	always_comb begin
		mode_nxt = pin_sync_r;
		valid_nxt = (pin_sync_r != mode_ctrl_pkg::MODE_NONE);
		init16 = 1'b0;
		rom_nxt = 1'b0;
		space_nxt = mode_ctrl_pkg::SPACE_NONE;
		single_nxt = 1'b0;
		adv_nxt = 1'b0;
		ports_nxt = 1'b0;
		case (pin_sync_r)
			mode_ctrl_pkg::MODE_1: begin
				space_nxt = mode_ctrl_pkg::SPACE_1M;
				ports_nxt = 1'b1;
			end
			mode_ctrl_pkg::MODE_2: begin
				init16 = 1'b1;
				space_nxt = mode_ctrl_pkg::SPACE_1M;
				ports_nxt = 1'b1;
			end
			mode_ctrl_pkg::MODE_3: begin
				space_nxt = mode_ctrl_pkg::SPACE_16M;
			end
			mode_ctrl_pkg::MODE_4: begin
				init16 = 1'b1;
				space_nxt = mode_ctrl_pkg::SPACE_16M;
			end
			mode_ctrl_pkg::MODE_5: begin
				rom_nxt = 1'b1;
				space_nxt = mode_ctrl_pkg::SPACE_1M;
			end
			mode_ctrl_pkg::MODE_6: begin
				rom_nxt = 1'b1;
				space_nxt = mode_ctrl_pkg::SPACE_64K;
				single_nxt = 1'b1;
			end
			mode_ctrl_pkg::MODE_7: begin
				rom_nxt = 1'b1;
				space_nxt = mode_ctrl_pkg::SPACE_1M;
				single_nxt = 1'b1;
				adv_nxt = 1'b1;
			end
			default: begin
				valid_nxt = 1'b0;
			end
		endcase
		expanded = valid_nxt && !single_nxt;
		// in expanded modes 1 to 5 bus width follows area control alone, single chip modes stay 8 bit; modes 2 and 4 read as 8 bit while it is zero
		bus16_nxt = expanded && (area_width_control_i != 8'h00);
		if (expanded && init16 && area_width_control_i == 8'h00) begin
			bus16_nxt = 1'b0;
		end
	end

	// ==========================================
	// address and ram routing
	logic [19:0] ext_addr_nxt;
	logic ram_sel_nxt;
	always_comb begin
		ext_addr_nxt = ports_nxt ? (cpu_addr_i & mode_ctrl_pkg::ADDR_1M_MASK) : 20'h00000;
		// in single chip modes ram is always on chip
		ram_sel_nxt = single_nxt || sysctl_r[mode_ctrl_pkg::BIT_RAM_EN];
	end

	// ==========================================
	// standby control decode
	logic sleep_nxt;
	logic standby_nxt;
	logic [17:0] wait_nxt;
	logic illegal_nxt;
	logic [2:0] settle;
	always_comb begin
		settle = sysctl_r[mode_ctrl_pkg::BIT_SETTLE_HI:mode_ctrl_pkg::BIT_SETTLE_LO];
		sleep_nxt = sleep_i && !sysctl_r[mode_ctrl_pkg::BIT_STANDBY];
		standby_nxt = sleep_i && sysctl_r[mode_ctrl_pkg::BIT_STANDBY];
		illegal_nxt = 1'b0;
		case (settle)
			3'h0: wait_nxt = mode_ctrl_pkg::WAIT_8K;
			3'h1: wait_nxt = mode_ctrl_pkg::WAIT_16K;
			3'h2: wait_nxt = mode_ctrl_pkg::WAIT_32K;
			3'h3: wait_nxt = mode_ctrl_pkg::WAIT_64K;
			3'h4: wait_nxt = mode_ctrl_pkg::WAIT_128K;
			3'h5: wait_nxt = mode_ctrl_pkg::WAIT_128K;
			default: begin
				wait_nxt = mode_ctrl_pkg::WAIT_ILLEGAL;
				illegal_nxt = 1'b1;
			end
		endcase
	end

	// ==========================================
	// output registers; all outputs straight from flops
	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			rdata_o <= 8'h00;
			mode_o <= 3'h0;
			mode_valid_o <= 1'b0;
			bus_16bit_o <= 1'b0;
			rom_enable_o <= 1'b0;
			addr_space_o <= 2'h0;
			single_chip_o <= 1'b0;
			advanced_o <= 1'b0;
			ports_address_o <= 1'b0;
			ext_addr_o <= 20'h00000;
			ram_select_o <= 1'b1;
			enter_sleep_o <= 1'b0;
			enter_standby_o <= 1'b0;
			settle_wait_o <= mode_ctrl_pkg::WAIT_8K;
			settle_illegal_o <= 1'b0;
			user_flag_enable_bit_o <= 1'b1;
			nmi_rising_o <= 1'b0;
		end else begin
			rdata_o <= rdata_nxt;
			mode_o <= mode_nxt;
			mode_valid_o <= valid_nxt;
			bus_16bit_o <= bus16_nxt;
			rom_enable_o <= rom_nxt;
			addr_space_o <= space_nxt;
			single_chip_o <= single_nxt;
			advanced_o <= adv_nxt;
			ports_address_o <= ports_nxt;
			ext_addr_o <= ext_addr_nxt;
			ram_select_o <= ram_sel_nxt;
			enter_sleep_o <= sleep_nxt;
			enter_standby_o <= standby_nxt;
			settle_wait_o <= wait_nxt;
			settle_illegal_o <= illegal_nxt;
			user_flag_enable_bit_o <= sysctl_r[mode_ctrl_pkg::BIT_USER_EN];
			nmi_rising_o <= sysctl_r[mode_ctrl_pkg::BIT_EDGE];
		end
	end
endmodule // mode_ctrl

// >>> sim/mode_strap_model.sv
// board strap model that holds the mode pins steady
`timescale 1ns/100ps
module mode_strap_model (
	input wire logic [2:0] strap_i,
	output logic [2:0] mode_pins_o
);
	// the bench changes the strap only while the block sits in reset
	assign mode_pins_o = strap_i;
endmodule // mode_strap_model

// >>> sim/mode_ctrl_asserts.sv
// concurrent checks on the mode and system control ports
`timescale 1ns/100ps
module mode_ctrl_asserts (
	input wire logic clock_i,
	input wire logic rst_i,
	input wire logic [15:0] addr_i,
	input wire logic rd_i,
	input wire logic sleep_i,
	input wire logic [7:0] area_width_control_i,
	input wire logic [7:0] rdata_o,
	input wire logic [2:0] mode_o,
	input wire logic mode_valid_o,
	input wire logic bus_16bit_o,
	input wire logic rom_enable_o,
	input wire logic [1:0] addr_space_o,
	input wire logic advanced_o,
	input wire logic enter_sleep_o,
	input wire logic enter_standby_o,
	input wire logic [17:0] settle_wait_o,
	input wire logic settle_illegal_o
);
	// ==========================================
	// properties
	default clocking @(posedge clock_i); endclocking
	default disable iff (rst_i);
	sequence s_rd_sys;
		rd_i && addr_i == mode_ctrl_pkg::ADDR_SYSTEM_CONTROL;
	endsequence
	property p_valid; mode_valid_o == (mode_o != 3'h0); endproperty
	property p_rom; rom_enable_o == (mode_o >= 3'h5); endproperty
	property p_space; addr_space_o == ((mode_o == 3'h6) ? 2'h1 :
		(mode_o == 3'h3 || mode_o == 3'h4) ? 2'h3 : (mode_o == 3'h0) ? 2'h0 : 2'h2); endproperty
	property p_adv; advanced_o == (mode_o == 3'h7); endproperty
	// width needs settled inputs, the output lags them by one cycle
	property p_bus; (mode_o inside {[3'h1:3'h5]} && area_width_control_i != 8'h00) ##1
		($stable(mode_o) && $stable(area_width_control_i)) |-> bus_16bit_o; endproperty
	property p_rb; rd_i && addr_i == mode_ctrl_pkg::ADDR_MODE_READBACK |=>
		rdata_o[7:3] == 5'h18; endproperty
	property p_bit1; s_rd_sys |=> rdata_o[1]; endproperty
	property p_sleep; sleep_i |=> enter_sleep_o != enter_standby_o; endproperty
	property p_settle; settle_illegal_o == (settle_wait_o == 18'h00000); endproperty
	a_valid: assert property (p_valid) else $error("mode valid flag wrong");
	a_rom: assert property (p_rom) else $error("rom enable wrong");
	a_space: assert property (p_space) else $error("address space wrong");
	a_adv: assert property (p_adv) else $error("advanced flag wrong");
	a_bus: assert property (p_bus) else $error("bus width wrong");
	a_rb: assert property (p_rb) else $error("readback fixed bits wrong");
	a_bit1: assert property (p_bit1) else $error("bit one not set");
	a_sleep: assert property (p_sleep) else $error("no single power down pulse");
	a_settle: assert property (p_settle) else $error("illegal flag wrong");
endmodule // mode_ctrl_asserts
bind mode_ctrl mode_ctrl_asserts i_mode_ctrl_asserts (.clock_i(clock_i), .rst_i(rst_i),
	.addr_i(addr_i), .rd_i(rd_i), .sleep_i(sleep_i), .area_width_control_i(area_width_control_i),
	.rdata_o(rdata_o), .mode_o(mode_o), .mode_valid_o(mode_valid_o), .bus_16bit_o(bus_16bit_o),
	.rom_enable_o(rom_enable_o), .addr_space_o(addr_space_o), .advanced_o(advanced_o),
	.enter_sleep_o(enter_sleep_o), .enter_standby_o(enter_standby_o),
	.settle_wait_o(settle_wait_o), .settle_illegal_o(settle_illegal_o));

// >>> sim/mcu_mode_and_system_control_tb_top.sv
// testbench for the mode and system control block
`timescale 1ns/100ps
`define CHK(n, e, s) begin n_compared++; if ((s) !== (e)) begin err_count++; \
	$display("[FAIL] %s exp %h got %h", n, e, s); end end
module mcu_mode_and_system_control_tb_top;
	logic clock_i = 1'b0;
	logic rst_i = 1'b1;
	logic wr = 1'b0, rd = 1'b0, slp = 1'b0;
	logic [2:0] strap = 3'h1, pins, mode;
	logic [15:0] addr = 16'h0000;
	logic [7:0] wd = 8'h00, awc = 8'h00, rdat, rv;
	logic [19:0] cpu = 20'habcde, ext;
	logic [17:0] stw;
	logic [1:0] spc;
	logic vld, b16, rom, sc, adv, pa, ram, esl, esb, ill, ue, nmi;
	int err_count = 0;
	int n_compared = 0;
	// ==========================================
	// clock, strap and device
	always #25 clock_i = ~clock_i;
	mode_strap_model i_mode_strap_model (.strap_i(strap), .mode_pins_o(pins));
	mode_ctrl i_mode_ctrl (.clock_i(clock_i), .rst_i(rst_i), .mode_pins_i(pins), .addr_i(addr),
		.wdata_i(wd), .wr_i(wr), .rd_i(rd), .area_width_control_i(awc), .sleep_i(slp),
		.cpu_addr_i(cpu), .rdata_o(rdat), .mode_o(mode), .mode_valid_o(vld), .bus_16bit_o(b16),
		.rom_enable_o(rom), .addr_space_o(spc), .single_chip_o(sc), .advanced_o(adv),
		.ports_address_o(pa), .ext_addr_o(ext), .ram_select_o(ram), .enter_sleep_o(esl),
		.enter_standby_o(esb), .settle_wait_o(stw), .settle_illegal_o(ill),
		.user_flag_enable_bit_o(ue), .nmi_rising_o(nmi));
	// ==========================================
	// bus and control tasks
	task automatic wr_reg(input logic [15:0] a, input logic [7:0] d);
		@(posedge clock_i); addr <= a; wd <= d; wr <= 1'b1;
		@(posedge clock_i); wr <= 1'b0;
	endtask
	// read data stand only in the cycle after the strobe
	task automatic rd_reg(input logic [15:0] a, output logic [7:0] d);
		@(posedge clock_i); addr <= a; rd <= 1'b1;
		@(posedge clock_i); rd <= 1'b0;
		#1 d = rdat;
	endtask
	// pins may only change under reset, so each mode gets a fresh reset
	task automatic restart(input logic [2:0] m);
		@(posedge clock_i); rst_i <= 1'b1; strap <= m; awc <= 8'h00;
		repeat (8) @(posedge clock_i); rst_i <= 1'b0;
		repeat (4) @(posedge clock_i); #1;
	endtask
	task automatic pulse_sleep();
		@(posedge clock_i); slp <= 1'b1;
		@(posedge clock_i); slp <= 1'b0;
		#1;
	endtask
	// ==========================================
	// scenarios
	task automatic t_modes();
		for (int m = 1; m < 8; m++) begin
			restart(m[2:0]);
			`CHK("valid", 1'b1, vld)
			`CHK("rom", (m >= 5), rom)
			`CHK("space", 16'h9be8 >> (2 * m) & 16'h3, {14'h0, spc})
			`CHK("single", (m >= 6), sc)
			`CHK("adv", (m == 7), adv)
			`CHK("ports", (m <= 2), pa)
			`CHK("ext", (m <= 2) ? cpu : 20'h00000, ext)
			`CHK("b8", 1'b0, b16)
			`CHK("ram on", 1'b1, ram)
			rd_reg(mode_ctrl_pkg::ADDR_MODE_READBACK, rv);
			`CHK("readback", {5'h18, m[2:0]}, rv)
			@(posedge clock_i);
			awc <= 8'h01;
			repeat (3) @(posedge clock_i);
			#1;
			`CHK("b16", (m <= 5), b16)
		end
		$display("test modes done");
	endtask
	task automatic t_sysctl();
		restart(3'h1);
		rd_reg(mode_ctrl_pkg::ADDR_SYSTEM_CONTROL, rv);
		`CHK("reset", 8'h0b, rv)
		`CHK("ue", 1'b1, ue)
		`CHK("nmi", 1'b0, nmi)
		`CHK("ram", 1'b1, ram)
		wr_reg(mode_ctrl_pkg::ADDR_SYSTEM_CONTROL, 8'h00);
		wr_reg(mode_ctrl_pkg::ADDR_MODE_READBACK, 8'h00);
		rd_reg(mode_ctrl_pkg::ADDR_SYSTEM_CONTROL, rv);
		`CHK("clear", 8'h02, rv)
		`CHK("ram off", 1'b0, ram)
		`CHK("ue off", 1'b0, ue)
		// single chip mode keeps ram on chip even with the enable bit clear
		restart(3'h7);
		wr_reg(mode_ctrl_pkg::ADDR_SYSTEM_CONTROL, 8'h00);
		repeat (2) @(posedge clock_i);
		#1;
		`CHK("ram single", 1'b1, ram)
		restart(3'h1);
		rd_reg(mode_ctrl_pkg::ADDR_MODE_READBACK, rv);
		`CHK("ro", 8'hc1, rv)
		rd_reg(16'hfff3, rv);
		`CHK("unmapped", 8'h00, rv)
		// codes swept by count only; the eight ms floor is software's duty
		for (int c = 0; c < 8; c++) begin
			wr_reg(mode_ctrl_pkg::ADDR_SYSTEM_CONTROL, {1'b1, c[2:0], 4'hf});
			rd_reg(mode_ctrl_pkg::ADDR_SYSTEM_CONTROL, rv);
			`CHK("wait", (c < 4) ? 18'h02000 << c : (c < 6) ? 18'h20000 : 18'h0, stw)
			`CHK("ill", (c >= 6), ill)
		end
		`CHK("nmi rise", 1'b1, nmi)
		pulse_sleep();
		`CHK("standby", 2'h1, {esl, esb})
		rd_reg(mode_ctrl_pkg::ADDR_SYSTEM_CONTROL, rv);
		`CHK("kept", 8'hff, rv)
		wr_reg(mode_ctrl_pkg::ADDR_SYSTEM_CONTROL, 8'h0b);
		pulse_sleep();
		`CHK("sleep", 2'h2, {esl, esb})
		$display("test sysctl done");
	endtask
	task automatic final_report();
		$display("compared %0d mismatches %0d", n_compared, err_count);
		if (err_count == 0 && n_compared > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	initial begin
		restart(3'h1);
		t_modes();
		t_sysctl();
		final_report();
	end
endmodule // mcu_mode_and_system_control_tb_top
